// ### core/rsm_regs.sv
// rail setpoint and operating-mode register slice
`timescale 1ns/1ns
// Operation
// (R1) rail1 code at 20h, resets 0111000
// (R2) zero code valid; power-good held high
// (R3) rail2 code at 21h, resets zero
// (R4) rail3 code at 23h, resets 0010001
// (R5) 25h bit1: rail4 forced PWM
// (R6) 26h bit1: rail5 forced PWM
// (R7) mode reset by variant; 7:6 read-only
// (R8) reserved bits read reset values
module rsm_regs #(
   parameter logic RAIL4_PWM_RST = 1'b0,
   parameter logic RAIL5_PWM_RST = 1'b0
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [rsm_pkg::ADDR_W-1:0] addr,
   input wire logic [rsm_pkg::DATA_W-1:0] wr_data,
   output logic [rsm_pkg::DATA_W-1:0] rd_data,
   output logic rd_hit,
   input wire logic sleep_state_n,
   input wire logic [2:0] rail_pgood_raw,
   output logic [2:0] rail_pgood,
   output logic [rsm_pkg::CODE_W-1:0] rail1_voltage_code,
   output logic [rsm_pkg::CODE_W-1:0] rail2_voltage_code,
   output logic [rsm_pkg::CODE_W-1:0] rail3_voltage_code,
   output logic rail4_pwm_force,
   output logic rail5_pwm_force
);
   import rsm_pkg::*;

   // only the stored fields are flops; reserved bits are rebuilt from their reset values on read
   localparam logic [7:0] MODE_FIELD = 8'h01 << MODE_BIT;
   logic [CODE_W-1:0] rail1_voltage_setting_r;
   logic [CODE_W-1:0] rail2_voltage_setting_r;
   logic [CODE_W-1:0] rail3_voltage_setting_r;
   logic rail4_mode_setting_r;
   logic rail5_mode_setting_r;
   logic [7:0] rail4_mode_read;
   logic [7:0] rail5_mode_read;
   logic pgood_force;
   logic addr_mapped;
   logic [7:0] rd_data_nxt;
   logic hit_nxt;
   logic any_zero;

   // ----------------------------------------
   // writable storage
   // ----------------------------------------
   // bit 7 is reserved and not stored, so a host write to it leaves the read-back at its reset value
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rail1_voltage_setting_r <= RST_RAIL1_VOLT[CODE_W-1:0]; // see (R1)
         rail2_voltage_setting_r <= RST_RAIL2_VOLT[CODE_W-1:0]; // see (R3)
         rail3_voltage_setting_r <= RST_RAIL3_VOLT[CODE_W-1:0]; // see (R4)
      end else if (wr_en) begin
         if (addr == OFS_RAIL1_VOLT) begin
            rail1_voltage_setting_r <= wr_data[CODE_W-1:0]; // see (R1)
         end
         if (addr == OFS_RAIL2_VOLT) begin
            rail2_voltage_setting_r <= wr_data[CODE_W-1:0]; // see (R3)
         end
         if (addr == OFS_RAIL3_VOLT) begin
            rail3_voltage_setting_r <= wr_data[CODE_W-1:0]; // see (R4)
         end
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rail4_mode_setting_r <= RAIL4_PWM_RST; // see (R7)
         rail5_mode_setting_r <= RAIL5_PWM_RST; // see (R7)
      end else if (wr_en) begin
         // read-only and reserved bits are not stored, so only the mode bit takes the write
         if (addr == OFS_RAIL4_MODE) begin
            rail4_mode_setting_r <= wr_data[MODE_BIT]; // see (R5) see (R8)
         end
         if (addr == OFS_RAIL5_MODE) begin
            rail5_mode_setting_r <= wr_data[MODE_BIT]; // see (R6) see (R8)
         end
      end
   end

   // ----------------------------------------
   // read path
   // ----------------------------------------
   // reserved mode bits are constants, so every variant reads them back at their reset value
   assign rail4_mode_read = RST_MODE_BASE | (8'({7'h00, rail4_mode_setting_r}) << MODE_BIT); // see (R7) see (R8)
   assign rail5_mode_read = RST_MODE_BASE | (8'({7'h00, rail5_mode_setting_r}) << MODE_BIT); // see (R7) see (R8)

   always_comb begin
      rd_data_nxt = 8'h00;
      hit_nxt = 1'b1;
      case (addr)
         OFS_RAIL1_VOLT: rd_data_nxt = (RST_RAIL1_VOLT & VOLT_RO_MASK) | 8'(rail1_voltage_setting_r); // see (R8)
         OFS_RAIL2_VOLT: rd_data_nxt = (RST_RAIL2_VOLT & VOLT_RO_MASK) | 8'(rail2_voltage_setting_r); // see (R8)
         OFS_RAIL3_VOLT: rd_data_nxt = (RST_RAIL3_VOLT & VOLT_RO_MASK) | 8'(rail3_voltage_setting_r); // see (R8)
         OFS_RAIL4_MODE: rd_data_nxt = rail4_mode_read; // see (R8)
         OFS_RAIL5_MODE: rd_data_nxt = rail5_mode_read; // see (R8)
         default: hit_nxt = 1'b0;
      endcase
   end

   // unmapped reads return zero with rd_hit low; other slices own those offsets
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= 8'h00;
         rd_hit <= 1'b0;
      end else if (rd_en) begin
         rd_data <= rd_data_nxt;
         rd_hit <= hit_nxt;
      end
   end

   // ----------------------------------------
   // outputs to the regulators
   // ----------------------------------------
   assign rail1_voltage_code = rail1_voltage_setting_r; // see (R1)
   assign rail2_voltage_code = rail2_voltage_setting_r; // see (R3)
   assign rail3_voltage_code = rail3_voltage_setting_r; // see (R4)
   assign rail4_pwm_force = rail4_mode_setting_r; // see (R5)
   assign rail5_pwm_force = rail5_mode_setting_r; // see (R6)

   // a zero code is a deliberate off target, so it must not flag a fault
   assign any_zero = (rail1_voltage_code == CODE_ZERO) || (rail2_voltage_code == CODE_ZERO)
                     || (rail3_voltage_code == CODE_ZERO);
   assign pgood_force = any_zero || !sleep_state_n; // see (R2)
   for (genvar g = 0; g < $bits(rail_pgood); g++) begin : g_pgood
      assign rail_pgood[g] = pgood_force ? 1'b1 : rail_pgood_raw[g]; // see (R2)
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_rail1_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R1)
      wr_en && addr == OFS_RAIL1_VOLT |=> rail1_voltage_code == $past(wr_data[6:0]))
      else $error("rail1 code did not follow write");
   a_rail3_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R4)
      !(wr_en && addr == OFS_RAIL3_VOLT) |=> $stable(rail3_voltage_code))
      else $error("rail3 code changed without write");
   a_rail2_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R3)
      wr_en && addr == OFS_RAIL2_VOLT |=> rail2_voltage_code == $past(wr_data[6:0]))
      else $error("rail2 code did not follow write");
   a_pgood_forced: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R2)
      (!sleep_state_n || rail1_voltage_code == CODE_ZERO || rail2_voltage_code == CODE_ZERO
       || rail3_voltage_code == CODE_ZERO) |-> rail_pgood == 3'h7)
      else $error("power good not held high");
   a_pgood_pass: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R2)
      sleep_state_n && !any_zero |-> rail_pgood == rail_pgood_raw)
      else $error("power good not passed through");
   a_rail4_mode: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R5)
      wr_en && addr == OFS_RAIL4_MODE |=> rail4_pwm_force == $past(wr_data[1]))
      else $error("rail4 mode did not follow write");
   a_rail5_mode: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R6)
      wr_en && addr == OFS_RAIL5_MODE |=> rail5_pwm_force == $past(wr_data[1]))
      else $error("rail5 mode did not follow write");
   a_mode_ro_bits: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R7)
      rd_en && (addr == OFS_RAIL4_MODE || addr == OFS_RAIL5_MODE) |=> (rd_data & MODE_RO_MASK) == 8'h00)
      else $error("mode read-only bits not zero");
   a_read_back: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R8)
      wr_en && addr == OFS_RAIL4_MODE ##1 !(wr_en && addr == OFS_RAIL4_MODE)
      ##1 rd_en && addr == OFS_RAIL4_MODE && !wr_en
      |=> rd_data == (RST_MODE_BASE | ($past(wr_data, 3) & MODE_FIELD)))
      else $error("mode register read-back wrong");

   // address decode kept apart from the read mux so the checks do not lean on it
   assign addr_mapped = addr == OFS_RAIL1_VOLT || addr == OFS_RAIL2_VOLT || addr == OFS_RAIL3_VOLT
                        || addr == OFS_RAIL4_MODE || addr == OFS_RAIL5_MODE;

   a_rail3_write: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R4)
      wr_en && addr == OFS_RAIL3_VOLT |=> rail3_voltage_code == $past(wr_data[CODE_W-1:0]))
      else $error("rail3 code did not follow write");
   a_rail1_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R1)
      !(wr_en && addr == OFS_RAIL1_VOLT) |=> $stable(rail1_voltage_code))
      else $error("rail1 code changed without write");
   a_rail2_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R3)
      !(wr_en && addr == OFS_RAIL2_VOLT) |=> $stable(rail2_voltage_code))
      else $error("rail2 code changed without write");
   a_rail4_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R5)
      !(wr_en && addr == OFS_RAIL4_MODE) |=> $stable(rail4_pwm_force))
      else $error("rail4 mode changed without write");
   a_rail5_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R6)
      !(wr_en && addr == OFS_RAIL5_MODE) |=> $stable(rail5_pwm_force))
      else $error("rail5 mode changed without write");

   a_volt_rsvd_bit: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R8)
      rd_en && (addr == OFS_RAIL1_VOLT || addr == OFS_RAIL2_VOLT || addr == OFS_RAIL3_VOLT)
      |=> (rd_data & VOLT_RO_MASK) == 8'h00)
      else $error("voltage reserved bit not at reset value");
   a_mode_rsvd_bits: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R8)
      rd_en && (addr == OFS_RAIL4_MODE || addr == OFS_RAIL5_MODE) |=> (rd_data & ~MODE_FIELD) == RST_MODE_BASE)
      else $error("mode reserved bits not at reset value");
   a_rail1_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R1)
      rd_en && addr == OFS_RAIL1_VOLT |=> rd_data[CODE_W-1:0] == $past(rail1_voltage_code))
      else $error("rail1 read-back differs from code");
   a_rail2_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R3)
      rd_en && addr == OFS_RAIL2_VOLT |=> rd_data[CODE_W-1:0] == $past(rail2_voltage_code))
      else $error("rail2 read-back differs from code");
   a_rail3_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R4)
      rd_en && addr == OFS_RAIL3_VOLT |=> rd_data[CODE_W-1:0] == $past(rail3_voltage_code))
      else $error("rail3 read-back differs from code");
   a_rail4_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R5)
      rd_en && addr == OFS_RAIL4_MODE |=> rd_data[MODE_BIT] == $past(rail4_pwm_force))
      else $error("rail4 read-back differs from mode");
   a_rail5_read: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R6)
      rd_en && addr == OFS_RAIL5_MODE |=> rd_data[MODE_BIT] == $past(rail5_pwm_force))
      else $error("rail5 read-back differs from mode");

   a_read_hit: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R8)
      rd_en && addr_mapped |=> rd_hit)
      else $error("mapped read did not report a hit");
   a_read_miss: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R8)
      rd_en && !addr_mapped |=> !rd_hit && rd_data == 8'h00)
      else $error("unmapped read not empty");
   a_read_hold: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R8)
      !rd_en |=> $stable(rd_data) && $stable(rd_hit))
      else $error("read result changed without a read");
   a_pgood_sleep: assert property (@(posedge clk_sys) disable iff (!arst_n) // see (R2)
      !sleep_state_n |-> rail_pgood == 3'h7)
      else $error("power good not held high in sleep");
endmodule : rsm_regs

// ### core/rsm_pkg.sv
// package: register offsets, reset values and field positions for the rail setpoint and mode slice
package rsm_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned CODE_W = 7;
   localparam logic [7:0] OFS_RAIL1_VOLT = 8'h20;
   localparam logic [7:0] OFS_RAIL2_VOLT = 8'h21;
   localparam logic [7:0] OFS_RAIL3_VOLT = 8'h23;
   localparam logic [7:0] OFS_RAIL4_MODE = 8'h25;
   localparam logic [7:0] OFS_RAIL5_MODE = 8'h26;
   localparam logic [7:0] RST_RAIL1_VOLT = 8'h38;
   localparam logic [7:0] RST_RAIL2_VOLT = 8'h00;
   localparam logic [7:0] RST_RAIL3_VOLT = 8'h11;
   // mode register without the variant-dependent mode bit
   localparam logic [7:0] RST_MODE_BASE = 8'h3d;
   localparam int unsigned MODE_BIT = 1;
   localparam logic [7:0] MODE_RO_MASK = 8'hc0;
   localparam logic [7:0] VOLT_RO_MASK = 8'h80;
   localparam logic [6:0] CODE_ZERO = 7'h00;
endpackage : rsm_pkg

// ### dv/rsm_host.sv
// host model: drives the register strobes of the rail slice
`timescale 1ns/1ns
module rsm_host (
   input wire logic clk_sys,
   output logic wr_en = 1'b0,
   output logic rd_en = 1'b0,
   output logic [7:0] addr = 8'h00,
   output logic [7:0] wr_data = 8'h00
);
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1;
   endtask : rd
endmodule : rsm_host

// ### dv/rsm_regs_test.sv
// self-checking bench for the rail setpoint and mode slice
`timescale 1ns/1ns
module rsm_regs_test;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic sleep_state_n = 1'b1;
   logic [2:0] pg_raw = 3'h0;
   logic wr_en, rd_en, rd_hit, f4, f5;
   logic [7:0] addr, wr_data, rd_data;
   logic [6:0] c1, c2, c3;
   logic [2:0] pg;
   int mismatches = 0;
   int samples_checked = 0;
   always #5 clk_sys = ~clk_sys;
   rsm_host i_rsm_host (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data));
   // rail5 built as the forced-pwm variant so both reset values are seen
   rsm_regs #(.RAIL4_PWM_RST(1'b0), .RAIL5_PWM_RST(1'b1)) i_rsm_regs (.clk_sys(clk_sys), .arst_n(arst_n),
      .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wr_data(wr_data), .rd_data(rd_data), .rd_hit(rd_hit),
      .sleep_state_n(sleep_state_n), .rail_pgood_raw(pg_raw), .rail_pgood(pg), .rail1_voltage_code(c1),
      .rail2_voltage_code(c2), .rail3_voltage_code(c3), .rail4_pwm_force(f4), .rail5_pwm_force(f5));
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic h);
      i_rsm_host.rd(a);
      chk("rd_data", e, rd_data);
      chk("rd_hit", {7'h0, h}, {7'h0, rd_hit});
   endtask : rchk
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   initial begin
      // the sequence needs about 50 cycles; give it forty times that
      #20000;
      mismatches++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge clk_sys);
      chk("pgood", 8'h07, {5'h0, pg});
      arst_n <= 1'b1;
      rchk(8'h20, 8'h38, 1'b1);
      rchk(8'h21, 8'h00, 1'b1);
      rchk(8'h23, 8'h11, 1'b1);
      rchk(8'h25, 8'h3d, 1'b1);
      rchk(8'h26, 8'h3f, 1'b1);
      chk("f4", 8'h00, {7'h0, f4});
      chk("f5", 8'h01, {7'h0, f5});
      i_rsm_host.wr(8'h25, 8'hff);
      rchk(8'h25, 8'h3f, 1'b1);
      chk("f4", 8'h01, {7'h0, f4});
      i_rsm_host.wr(8'h26, 8'h00);
      rchk(8'h26, 8'h3d, 1'b1);
      chk("f5", 8'h00, {7'h0, f5});
      i_rsm_host.wr(8'h20, 8'h8a);
      rchk(8'h20, 8'h0a, 1'b1);
      chk("c1", 8'h0a, {1'b0, c1});
      i_rsm_host.wr(8'h21, 8'h55);
      chk("c2", 8'h55, {1'b0, c2});
      i_rsm_host.wr(8'h23, 8'h7f);
      chk("c3", 8'h7f, {1'b0, c3});
      @(posedge clk_sys);
      pg_raw <= 3'h5;
      #1;
      chk("pgood", 8'h05, {5'h0, pg});
      @(posedge clk_sys);
      sleep_state_n <= 1'b0;
      #1;
      chk("pgood", 8'h07, {5'h0, pg});
      @(posedge clk_sys);
      sleep_state_n <= 1'b1;
      i_rsm_host.wr(8'h22, 8'hff);
      rchk(8'h22, 8'h00, 1'b0);
      rchk(8'h21, 8'h55, 1'b1);
      i_rsm_host.wr(8'h23, 8'h00);
      chk("pgood", 8'h07, {5'h0, pg});
      // a reset in mid-run must bring back the reset values of rail1, rail2, rail4 mode and rail5 mode; rail3 is not rechecked
      @(posedge clk_sys);
      arst_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      rchk(8'h20, 8'h38, 1'b1);
      rchk(8'h26, 8'h3f, 1'b1);
      chk("f4", 8'h00, {7'h0, f4});
      chk("c2", 8'h00, {1'b0, c2});
      report_and_stop();
   end
endmodule : rsm_regs_test
